/* hdl/cfm_pkg.sv */
package cfm_pkg;

  // Clock rate and fault timing.
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TRIG_NEUTRAL_MS = 5000;
  localparam int unsigned TRIG_NEUTRAL_CYC = TRIG_NEUTRAL_MS * (CLK_HZ / 1000);
  localparam int unsigned MS_CYC = CLK_HZ / 1000;

  // Fault codes (decimal as shown on the service display).
  localparam logic [15:0] FC_POWER_CYCLE = 16'h00D3;
  localparam logic [15:0] FC_KEY_BOTH = 16'h00D4;
  localparam logic [15:0] FC_HORN_STUCK = 16'h00DD;
  localparam logic [15:0] FC_TRIG_NEUTRAL = 16'h08A2;
  localparam logic [15:0] FC_INOUT_STUCK = 16'h00DE;
  localparam logic [15:0] FC_SEL_BOTH = 16'h00DF;
  localparam logic [15:0] FC_SEL_NONE = 16'h08B8;
  localparam logic [15:0] FC_STEERL_STUCK = 16'h00E0;

  // Flash codes: high nibble major blinks, low nibble minor blinks.
  localparam logic [7:0] FLASH_2_1 = 8'h21;
  localparam logic [7:0] FLASH_2_2 = 8'h22;

  // Market codes for which the indoor/outdoor startup check applies.
  localparam logic [2:0] MKT_A = 3'h1;
  localparam logic [2:0] MKT_B = 3'h2;
  localparam logic [2:0] MKT_C = 3'h3;
  localparam logic [2:0] MKT_D = 3'h4;

  // Fault bit positions.
  localparam int unsigned FB_KEY = 0;
  localparam int unsigned FB_HORN = 1;
  localparam int unsigned FB_TRIG = 2;
  localparam int unsigned FB_INOUT = 3;
  localparam int unsigned FB_SELB = 4;
  localparam int unsigned FB_SELN = 5;
  localparam int unsigned FB_STEER = 6;
  localparam int unsigned FB_PWR = 7;
  localparam int unsigned NFAULT = 8;

  // Register map.
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CLEAR = 4'h1;
  localparam logic [3:0] REG_ENABLE = 4'h2;
  localparam logic [3:0] REG_ACTIVE = 4'h3;
  localparam logic [3:0] REG_MARKET = 4'h4;
  localparam logic [3:0] REG_LOGCNT = 4'h5;
  localparam logic [3:0] REG_LOGPTR = 4'h6;
  localparam logic [3:0] REG_LOGDAT = 4'h7;
  localparam logic [3:0] REG_LASTPWR = 4'h8;
  localparam logic [3:0] REG_FLASH = 4'h9;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [2:0] MARKET_RST = 3'h0;

  typedef enum logic [2:0] {
    CFM_ST_BOOT = 3'b001,
    CFM_ST_STARTUP = 3'b010,
    CFM_ST_RUN = 3'b100
  } cfm_state_t;

endpackage

/* hdl/cfm_held_fault.sv */
// Sticky fault: set by its condition, held until the release level is seen.
module cfm_held_fault (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic set_i,
  input wire logic release_i,
  output logic active
);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      active <= 1'b0;
    end else if (set_i) begin
      active <= 1'b1;
    end else if (release_i) begin
      active <= 1'b0;
    end
  end

endmodule

/* hdl/cfm_log_mem.sv */
// Failure log storage with registered read data.
module cfm_log_mem #(
  parameter int unsigned AW = 5,
  parameter int unsigned DW = 16
) (
  input wire logic clk_sys,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

/* hdl/cfm_monitor.sv */
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Log power-cycle code, flash 2_1, each power-up unless another fault sets with it.
// - Log separates entries since last power-up.
// - Both key selects: fault 212, force ground.
// - Horn at startup: fault 221, block horn.
// - Trigger 5000 ms in neutral: fault 2210.
// - Fault 2210 blocks trigger, drive, lift.
// - In/out at startup: fault 222, keep mode.
// - In/out check only for four markets.
// - Both drive/lift selects: 223, lift, block.
// - Fault 223 held until either opens.
// - Neither select: 2232, lift, block, hold.
// - Steer left at startup: 224, block drive.
module cfm_monitor
  import cfm_pkg::*;
#(
  parameter int unsigned TRIG_CYC = TRIG_NEUTRAL_CYC,
  parameter int unsigned LOG_AW = 5
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ground_select_input,
  input wire logic platform_select_input,
  input wire logic horn_input,
  input wire logic trigger_input,
  input wire logic joystick_neutral,
  input wire logic indoor_outdoor_input,
  input wire logic drive_select_input,
  input wire logic lift_select_input,
  input wire logic steer_left_switch,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic irq,
  output logic ground_mode,
  output logic horn_enable,
  output logic trigger_state,
  output logic move_lift,
  output logic drive_prevented,
  output logic lift_up_prevented,
  output logic lift_down_prevented,
  output logic outdoor_mode,
  output logic [15:0] fault_code,
  output logic [7:0] flash_code
);

  ////////////////////////////////////////////////////////////////////////////
  // Power-up sequencing and platform startup detection.
  cfm_state_t state_r;
  cfm_state_t state_nxt;
  logic plat_mode;
  logic key_both;
  assign key_both = ground_select_input & platform_select_input;
  assign plat_mode = platform_select_input & ~ground_select_input;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      CFM_ST_BOOT: state_nxt = CFM_ST_RUN;
      CFM_ST_RUN: begin
        if (plat_mode) begin
          state_nxt = CFM_ST_STARTUP;
        end
      end
      CFM_ST_STARTUP: begin
        if (!plat_mode) begin
          state_nxt = CFM_ST_RUN;
        end
      end
      default: state_nxt = CFM_ST_BOOT;
    endcase
  end

  logic plat_prev_r;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_r <= CFM_ST_BOOT;
      plat_prev_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      plat_prev_r <= plat_mode;
    end
  end

  // Platform startup is the first cycle in platform mode.
  logic plat_start;
  logic boot;
  assign plat_start = plat_mode & ~plat_prev_r;
  assign boot = (state_r == CFM_ST_BOOT);

  ////////////////////////////////////////////////////////////////////////////
  // Trigger-in-neutral timer.
  logic [$clog2(TRIG_CYC+1)-1:0] trig_cnt_r;
  logic trig_arm;
  logic trig_done;
  assign trig_arm = plat_mode & trigger_input & joystick_neutral;
  assign trig_done = trig_arm & (trig_cnt_r == ($bits(trig_cnt_r))'(TRIG_CYC - 1));

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      trig_cnt_r <= '0;
    end else if (!trig_arm) begin
      trig_cnt_r <= '0;
    end else if (!trig_done) begin
      trig_cnt_r <= trig_cnt_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register: market.
  logic [2:0] market_r;
  logic inout_check;
  assign inout_check = (market_r == MKT_A) | (market_r == MKT_B) |
                       (market_r == MKT_C) | (market_r == MKT_D);

  ////////////////////////////////////////////////////////////////////////////
  // Held faults.
  logic [NFAULT-1:0] f_set;
  logic [NFAULT-1:0] f_rel;
  logic [NFAULT-1:0] f_act;
  logic sel_both;
  logic sel_none;
  assign sel_both = drive_select_input & lift_select_input;
  assign sel_none = ~drive_select_input & ~lift_select_input;

  assign f_set[FB_KEY] = key_both;
  assign f_rel[FB_KEY] = ~key_both;
  assign f_set[FB_HORN] = plat_start & horn_input;
  assign f_rel[FB_HORN] = ~horn_input;
  assign f_set[FB_TRIG] = trig_done;
  assign f_rel[FB_TRIG] = ~trigger_input;
  assign f_set[FB_INOUT] = plat_start & indoor_outdoor_input & inout_check;
  assign f_rel[FB_INOUT] = ~indoor_outdoor_input;
  assign f_set[FB_SELB] = plat_mode & sel_both;
  assign f_rel[FB_SELB] = ~sel_both;
  assign f_set[FB_SELN] = plat_mode & sel_none;
  assign f_rel[FB_SELN] = ~sel_none;
  assign f_set[FB_STEER] = plat_start & steer_left_switch;
  assign f_rel[FB_STEER] = ~steer_left_switch;
  assign f_set[FB_PWR] = boot;
  assign f_rel[FB_PWR] = 1'b1;

  genvar gi;
  generate
    for (gi = 0; gi < NFAULT; gi++) begin : g_fault
      cfm_held_fault u_fault (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .set_i(f_set[gi]),
        .release_i(f_rel[gi]),
        .active(f_act[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Motion outputs.
  logic sel_fault;
  assign sel_fault = f_act[FB_SELB] | f_act[FB_SELN];
  assign ground_mode = f_act[FB_KEY] | ~platform_select_input;
  assign horn_enable = horn_input & ~f_act[FB_HORN];
  assign trigger_state = trigger_input & ~f_act[FB_TRIG];
  assign move_lift = sel_fault | lift_select_input;
  assign drive_prevented = f_act[FB_TRIG] | sel_fault | f_act[FB_STEER];
  assign lift_up_prevented = f_act[FB_TRIG] | sel_fault;
  assign lift_down_prevented = f_act[FB_TRIG] | sel_fault;

  // Indoor/outdoor selection toggles on each press of the switch except while held.
  logic outdoor_r;
  logic inout_prev_r;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      outdoor_r <= 1'b0;
      inout_prev_r <= 1'b0;
    end else begin
      inout_prev_r <= indoor_outdoor_input;
      if (indoor_outdoor_input & ~inout_prev_r & ~f_act[FB_INOUT] & ~f_set[FB_INOUT]) begin
        outdoor_r <= ~outdoor_r;
      end
    end
  end
  assign outdoor_mode = outdoor_r;

  ////////////////////////////////////////////////////////////////////////////
  // New-fault events, reported code and log write.
  logic [NFAULT-1:0] f_prev_r;
  logic [NFAULT-1:0] f_new;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      f_prev_r <= '0;
    end else begin
      f_prev_r <= f_act;
    end
  end
  assign f_new = f_act & ~f_prev_r;

  logic [15:0] code_sel;
  logic [7:0] flash_sel;
  always_comb begin
    code_sel = 16'h0000;
    flash_sel = 8'h00;
    for (int i = NFAULT - 1; i >= 0; i--) begin
      if (f_new[i]) begin
        unique case (i)
          FB_KEY: code_sel = FC_KEY_BOTH;
          FB_HORN: code_sel = FC_HORN_STUCK;
          FB_TRIG: code_sel = FC_TRIG_NEUTRAL;
          FB_INOUT: code_sel = FC_INOUT_STUCK;
          FB_SELB: code_sel = FC_SEL_BOTH;
          FB_SELN: code_sel = FC_SEL_NONE;
          FB_STEER: code_sel = FC_STEERL_STUCK;
          default: code_sel = FC_POWER_CYCLE;
        endcase
        flash_sel = (i == FB_KEY || i == FB_PWR) ? FLASH_2_1 : FLASH_2_2;
      end
    end
  end

  // Lowest-numbered new fault wins; others in the same cycle are only flagged.
  logic log_we;
  logic [LOG_AW-1:0] log_wp_r;
  logic [LOG_AW-1:0] log_rp_r;
  logic [LOG_AW-1:0] last_pwr_r;
  logic [15:0] log_cnt_r;
  logic [15:0] log_rdata;
  assign log_we = |f_new;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fault_code <= 16'h0000;
      flash_code <= 8'h00;
      log_wp_r <= '0;
      last_pwr_r <= '0;
      log_cnt_r <= 16'h0000;
    end else if (log_we) begin
      fault_code <= code_sel;
      flash_code <= flash_sel;
      log_wp_r <= log_wp_r + 1'b1;
      log_cnt_r <= log_cnt_r + 16'h0001;
      if (f_new[FB_PWR]) begin
        last_pwr_r <= log_wp_r;
      end
    end
  end

  cfm_log_mem #(
    .AW(LOG_AW),
    .DW(16)
  ) u_log (
    .clk_sys(clk_sys),
    .we(log_we),
    .waddr(log_wp_r),
    .wdata(code_sel),
    .raddr(log_rp_r),
    .rdata(log_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register port and interrupt.
  logic [NFAULT-1:0] status_r;
  logic [NFAULT-1:0] enable_r;
  logic wr_clear;
  logic wr_enable;
  logic wr_market;
  logic wr_logptr;
  assign wr_clear = wr & (addr == REG_CLEAR);
  assign wr_enable = wr & (addr == REG_ENABLE);
  assign wr_market = wr & (addr == REG_MARKET);
  assign wr_logptr = wr & (addr == REG_LOGPTR);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      status_r <= '0;
      enable_r <= ENABLE_RST;
      market_r <= MARKET_RST;
      log_rp_r <= '0;
    end else begin
      // Set wins over a clear in the same cycle.
      status_r <= (status_r & ~(wr_clear ? wdata : 8'h00)) | f_new;
      if (wr_enable) begin
        enable_r <= wdata;
      end
      if (wr_market) begin
        market_r <= wdata[2:0];
      end
      if (wr_logptr) begin
        log_rp_r <= wdata[LOG_AW-1:0];
      end
    end
  end
  assign irq = |(status_r & enable_r);

  logic [15:0] rd_mux;
  always_comb begin
    unique case (addr)
      REG_STATUS: rd_mux = {8'h00, status_r};
      REG_ENABLE: rd_mux = {8'h00, enable_r};
      REG_ACTIVE: rd_mux = {8'h00, f_act};
      REG_MARKET: rd_mux = {13'h0000, market_r};
      REG_LOGCNT: rd_mux = log_cnt_r;
      REG_LOGPTR: rd_mux = {{(16-LOG_AW){1'b0}}, log_wp_r};
      REG_LASTPWR: rd_mux = {{(16-LOG_AW){1'b0}}, last_pwr_r};
      REG_FLASH: rd_mux = {8'h00, flash_code};
      default: rd_mux = 16'h0000;
    endcase
  end

  // Log data come straight from the memory's output register.
  logic rd_log_r;
  logic [15:0] rd_hold_r;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_hold_r <= 16'h0000;
      rd_log_r <= 1'b0;
    end else begin
      rd_log_r <= rd & (addr == REG_LOGDAT);
      rd_hold_r <= rd ? rd_mux : 16'h0000;
    end
  end
  assign rdata = rd_log_r ? log_rdata : rd_hold_r;

endmodule

/* bench/cfm_switch_box.sv */
module cfm_switch_box (
  input wire logic clk_sys,
  input wire logic [8:0] want,
  output logic [8:0] sw
);
  timeunit 1ns;
  timeprecision 1ns;
  // Contacts settle one clock after the operator moves them.
  always @(posedge clk_sys) begin
    sw <= want;
  end
endmodule

/* bench/cfm_checker.sv */
module cfm_checker
  import cfm_pkg::*;
#(
  parameter int unsigned TRIG_CYC = 20
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ground_select_input,
  input wire logic platform_select_input,
  input wire logic horn_input,
  input wire logic trigger_input,
  input wire logic joystick_neutral,
  input wire logic drive_select_input,
  input wire logic lift_select_input,
  input wire logic ground_mode,
  input wire logic horn_enable,
  input wire logic trigger_state,
  input wire logic move_lift,
  input wire logic drive_prevented,
  input wire logic lift_up_prevented,
  input wire logic lift_down_prevented,
  input wire logic [15:0] fault_code,
  input wire logic [7:0] flash_code
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pm;
  logic blk;
  logic [31:0] tcnt_r;
  assign pm = platform_select_input & ~ground_select_input;
  assign blk = drive_prevented & lift_up_prevented & lift_down_prevented;
  // Counts consecutive cycles of trigger held with the joystick centred.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tcnt_r <= '0;
    end else begin
      tcnt_r <= (pm && trigger_input && joystick_neutral) ? tcnt_r + 32'h1 : '0;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_power_code: assert property ($rose(resetn) |->
    ##[1:3] (fault_code == FC_POWER_CYCLE && flash_code == FLASH_2_1))
    else $error("power-up code missing");
  a_key_ground: assert property (
    ground_select_input && platform_select_input |=> ground_mode)
    else $error("ground mode not forced");
  a_horn_start: assert property ($rose(pm) && horn_input |=> !horn_enable)
    else $error("horn not blocked");
  a_sel_both: assert property (
    pm && drive_select_input && lift_select_input |=> move_lift && blk)
    else $error("both selects not blocked");
  a_sel_none: assert property (
    pm && !drive_select_input && !lift_select_input |=> move_lift && blk)
    else $error("no select not blocked");
  a_sel_free: assert property (
    (pm && drive_select_input && !lift_select_input) [*2] |-> !move_lift)
    else $error("select fault not released");
  a_trig_block: assert property (tcnt_r >= TRIG_CYC |-> !trigger_state && blk)
    else $error("trigger fault not applied");
  a_trig_flash: assert property (
    fault_code == FC_TRIG_NEUTRAL |-> flash_code == FLASH_2_2)
    else $error("trigger flash code wrong");
endmodule

bind cfm_monitor cfm_checker #(.TRIG_CYC(TRIG_CYC)) i_cfm_checker (
  .clk_sys(clk_sys), .resetn(resetn), .ground_select_input(ground_select_input),
  .platform_select_input(platform_select_input), .horn_input(horn_input),
  .trigger_input(trigger_input), .joystick_neutral(joystick_neutral),
  .drive_select_input(drive_select_input), .lift_select_input(lift_select_input),
  .ground_mode(ground_mode), .horn_enable(horn_enable), .trigger_state(trigger_state),
  .move_lift(move_lift), .drive_prevented(drive_prevented),
  .lift_up_prevented(lift_up_prevented), .lift_down_prevented(lift_down_prevented),
  .fault_code(fault_code), .flash_code(flash_code));

/* bench/tb.sv */
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end

module tb
  import cfm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned TC = 20;
  localparam logic [8:0] S_G = 9'h001;
  localparam logic [8:0] S_P = 9'h002;
  localparam logic [8:0] S_H = 9'h004;
  localparam logic [8:0] S_T = 9'h008;
  localparam logic [8:0] S_N = 9'h010;
  localparam logic [8:0] S_IO = 9'h020;
  localparam logic [8:0] S_DR = 9'h040;
  localparam logic [8:0] S_LF = 9'h080;
  localparam logic [8:0] S_ST = 9'h100;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [8:0] want = 9'h000;
  logic [8:0] sw;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata, fault_code, d;
  logic [7:0] flash_code;
  logic irq, ground_mode, horn_enable, trigger_state, move_lift, outdoor_mode, om;
  logic drive_prevented, lift_up_prevented, lift_down_prevented;
  logic [1:0] r;
  int fails = 0;
  int check_count = 0;

  always #50 clk_sys = ~clk_sys;

  cfm_switch_box i_cfm_switch_box (.clk_sys(clk_sys), .want(want), .sw(sw));
  cfm_monitor #(.TRIG_CYC(TC)) i_cfm_monitor (
    .clk_sys(clk_sys), .resetn(resetn), .ground_select_input(sw[0]),
    .platform_select_input(sw[1]), .horn_input(sw[2]), .trigger_input(sw[3]),
    .joystick_neutral(sw[4]), .indoor_outdoor_input(sw[5]), .drive_select_input(sw[6]),
    .lift_select_input(sw[7]), .steer_left_switch(sw[8]), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .ground_mode(ground_mode),
    .horn_enable(horn_enable), .trigger_state(trigger_state), .move_lift(move_lift),
    .drive_prevented(drive_prevented), .lift_up_prevented(lift_up_prevented),
    .lift_down_prevented(lift_down_prevented), .outdoor_mode(outdoor_mode),
    .fault_code(fault_code), .flash_code(flash_code));

  ////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic apply(input logic [8:0] v, input int n);
    @(posedge clk_sys);
    want <= v;
    tick(n);
  endtask

  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rreg(input logic [3:0] a);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  function automatic logic sel_bad(input logic dv, input logic lv);
    return dv == lv;
  endfunction

  task automatic complete_run();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  initial begin
    void'($urandom(32));
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    tick(4);
    `CHK("fault_code", FC_POWER_CYCLE, fault_code)
    `CHK("flash_code", FLASH_2_1, flash_code)
    rreg(REG_LASTPWR);
    wreg(REG_LOGPTR, d[7:0]);
    rreg(REG_LOGDAT);
    `CHK("log_power", FC_POWER_CYCLE, d)
    rreg(REG_ENABLE);
    `CHK("enable", {8'h00, ENABLE_RST}, d)
    rreg(REG_MARKET);
    `CHK("market", {13'h0000, MARKET_RST}, d)
    rreg(4'hF);
    `CHK("unmapped", 16'h0000, d)
    wreg(REG_ENABLE, 8'h80);
    tick(1);
    `CHK("irq_on", 1'b1, irq)
    wreg(REG_ENABLE, 8'h00);
    tick(1);
    `CHK("irq_masked", 1'b0, irq)
    wreg(REG_ENABLE, 8'hFF);
    wreg(REG_CLEAR, 8'hFF);
    tick(1);
    `CHK("irq_cleared", 1'b0, irq)
    apply(S_G | S_P, 3);
    `CHK("ground_mode", 1'b1, ground_mode)
    tick(1);
    `CHK("fault_code", FC_KEY_BOTH, fault_code)
    `CHK("flash_code", FLASH_2_1, flash_code)
    for (int m = 0; m < 8; m++) begin
      wreg(REG_MARKET, 8'(m));
      apply(S_G, 2);
      wreg(REG_CLEAR, 8'hFF);
      om = outdoor_mode;
      apply(S_P | S_H | S_IO | S_ST | S_DR, 3);
      `CHK("horn_enable", 1'b0, horn_enable)
      `CHK("drive_prevented", 1'b1, drive_prevented)
      if (m >= 1 && m <= 4) `CHK("outdoor_mode", om, outdoor_mode)
      else `CHK("outdoor_mode", ~om, outdoor_mode)
      rreg(REG_STATUS);
      `CHK("status_inout", (m >= 1 && m <= 4), d[FB_INOUT])
      `CHK("status_horn", 1'b1, d[FB_HORN])
      `CHK("fault_code", FC_HORN_STUCK, fault_code)
      `CHK("flash_code", FLASH_2_2, flash_code)
    end
    apply(S_P | S_DR, 1);
    apply(S_P | S_DR | S_H | S_ST, 3);
    `CHK("horn_enable", 1'b1, horn_enable)
    `CHK("drive_prevented", 1'b0, drive_prevented)
    apply(S_P | S_DR | S_LF, 4);
    `CHK("fault_code", FC_SEL_BOTH, fault_code)
    apply(S_P, 4);
    `CHK("fault_code", FC_SEL_NONE, fault_code)
    apply(S_P | S_DR | S_T | S_N, TC - 4);
    `CHK("trigger_state", 1'b1, trigger_state)
    tick(8);
    `CHK("trigger_state", 1'b0, trigger_state)
    `CHK("drive_prevented", 1'b1, drive_prevented)
    `CHK("fault_code", FC_TRIG_NEUTRAL, fault_code)
    apply(S_P | S_DR | S_N, 1);
    apply(S_P | S_DR | S_T | S_N, 3);
    `CHK("trigger_state", 1'b1, trigger_state)
    rreg(REG_LOGPTR);
    wreg(REG_LOGPTR, {3'h0, d[4:0] - 5'h01});
    rreg(REG_LOGDAT);
    `CHK("log_last", FC_TRIG_NEUTRAL, d)
    rreg(REG_LOGCNT);
    `CHK("log_count", 16'h000D, d)
    rreg(REG_FLASH);
    `CHK("flash_reg", {8'h00, FLASH_2_2}, d)
    for (int i = 0; i < 24; i++) begin
      r = 2'($urandom);
      apply(S_P | (r[0] ? S_DR : 9'h000) | (r[1] ? S_LF : 9'h000), 3);
      `CHK("drive_prevented", sel_bad(r[0], r[1]), drive_prevented)
      `CHK("move_lift", sel_bad(r[0], r[1]) | r[1], move_lift)
    end
    apply(S_G, 2);
    apply(S_P | S_ST | S_DR, 3);
    `CHK("fault_code", FC_STEERL_STUCK, fault_code)
    `CHK("flash_code", FLASH_2_2, flash_code)
    `CHK("drive_prevented", 1'b1, drive_prevented)
    complete_run();
  end

  initial begin
    #3_000_000;
    fails++;
    complete_run();
  end
endmodule
